//--- inc/lbs_consts.vh
`ifndef LBS_CONSTS_VH
`define LBS_CONSTS_VH
// Register select codes on the write and read ports
`define LBS_SEL_GENERAL 3'h0
`define LBS_SEL_CONFIG  3'h1
`define LBS_SEL_CHA     3'h2
`define LBS_SEL_CH3     3'h3
`define LBS_SEL_CH4     3'h4
`define LBS_SEL_CH5     3'h5
`define LBS_SEL_CH6     3'h6
// General register fields
`define LBS_GEN_PWM     7
`define LBS_GEN_FS_HI   6
`define LBS_GEN_FS_LO   5
`define LBS_GEN_EN6     4
`define LBS_GEN_EN5     3
`define LBS_GEN_EN4     2
`define LBS_GEN_EN3     1
`define LBS_GEN_ENA     0
// Config register fields
`define LBS_CFG_T56     7
`define LBS_CFG_T34     6
`define LBS_CFG_S6A     5
`define LBS_CFG_S5A     4
`define LBS_CFG_S4A     3
`define LBS_CFG_S3A     2
`define LBS_CFG_RS_HI   1
`define LBS_CFG_RS_LO   0
// Reset values
`define LBS_GENERAL_RST 8'h00
`define LBS_CONFIG_RST  8'h00
`define LBS_CODE_RST    6'h3F
`define LBS_RSVD_BITS   2'h3
`define LBS_LEVEL_RST   17'h1_86A0
// Timing, in microseconds, and the clock rate
`define LBS_CLK_MHZ     50
`define LBS_STEP0_US    100
`define LBS_STEP1_US    25000
`define LBS_STEP2_US    50000
`define LBS_STEP3_US    100000
`define LBS_SOFT_US     250
`endif

//--- logic/lbs_level_rom.v
`timescale 1ns/1ps
`include "lbs_consts.vh"
// Current level in thousandths of a percent of full scale
module lbs_level_rom (
   input  wire        clock,
   input  wire        sys_rst,
   input  wire [5:0]  code,
   output reg  [16:0] level_q
);
   reg [16:0] level_d;

   always @* begin
      case (code)
         6'h00: level_d = 17'h0_007D;
         6'h01: level_d = 17'h0_00BC;
         6'h02: level_d = 17'h0_00F9;
         6'h03: level_d = 17'h0_0138;
         6'h04: level_d = 17'h0_0176;
         6'h05: level_d = 17'h0_01B6;
         6'h06: level_d = 17'h0_01F3;
         6'h07: level_d = 17'h0_0230;
         6'h08: level_d = 17'h0_026E;
         6'h09: level_d = 17'h0_02B4;
         6'h0A: level_d = 17'h0_02EE;
         6'h0B: level_d = 17'h0_032A;
         6'h0C: level_d = 17'h0_036B;
         6'h0D: level_d = 17'h0_03AA;
         6'h0E: level_d = 17'h0_03EC;
         6'h0F: level_d = 17'h0_0464;
         6'h10: level_d = 17'h0_04E2;
         6'h11: level_d = 17'h0_055F;
         6'h12: level_d = 17'h0_05DB;
         6'h13: level_d = 17'h0_0659;
         6'h14: level_d = 17'h0_06D6;
         6'h15: level_d = 17'h0_0759;
         6'h16: level_d = 17'h0_080F;
         6'h17: level_d = 17'h0_08C9;
         6'h18: level_d = 17'h0_0986;
         6'h19: level_d = 17'h0_0A7F;
         6'h1A: level_d = 17'h0_0B7B;
         6'h1B: level_d = 17'h0_0C72;
         6'h1C: level_d = 17'h0_0DEA;
         6'h1D: level_d = 17'h0_0F60;
         6'h1E: level_d = 17'h0_10D6;
         6'h1F: level_d = 17'h0_12CD;
         6'h20: level_d = 17'h0_14C2;
         6'h21: level_d = 17'h0_1730;
         6'h22: level_d = 17'h0_19A5;
         6'h23: level_d = 17'h0_1C91;
         6'h24: level_d = 17'h0_1F7B;
         6'h25: level_d = 17'h0_22EA;
         6'h26: level_d = 17'h0_2694;
         6'h27: level_d = 17'h0_2A7A;
         6'h28: level_d = 17'h0_2EE5;
         6'h29: level_d = 17'h0_33C5;
         6'h2A: level_d = 17'h0_391A;
         6'h2B: level_d = 17'h0_3EFC;
         6'h2C: level_d = 17'h0_45D9;
         6'h2D: level_d = 17'h0_4DA3;
         6'h2E: level_d = 17'h0_5669;
         6'h2F: level_d = 17'h0_602D;
         6'h30: level_d = 17'h0_6AF0;
         6'h31: level_d = 17'h0_76A5;
         6'h32: level_d = 17'h0_8357;
         6'h33: level_d = 17'h0_9104;
         6'h34: level_d = 17'h0_9FA9;
         6'h35: level_d = 17'h0_AF4B;
         6'h36: level_d = 17'h0_BFE4;
         6'h37: level_d = 17'h0_D178;
         6'h38: level_d = 17'h0_E407;
         6'h39: level_d = 17'h0_F792;
         6'h3A: level_d = 17'h1_0C11;
         6'h3B: level_d = 17'h1_218A;
         6'h3C: level_d = 17'h1_3802;
         6'h3D: level_d = 17'h1_4F71;
         6'h3E: level_d = 17'h1_68D5;
         default: level_d = 17'h1_86A0;
      endcase
   end

   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         level_q <= `LBS_LEVEL_RST;
      end else begin
         level_q <= level_d;
      end
   end
endmodule // lbs_level_rom

//--- logic/lbs_led_sequencer.v
`timescale 1ns/1ps
`include "lbs_consts.vh"
// Summary of operation
// R1 - With pwm mode off and the enable pin low, everything including the serial port is off and registers reset.
// R2 - With the enable pin high the serial port works and the host turns channels on or off via the general register.
// R3 - Register reads and writes work whenever enabled, whether or not any channel is lit.
// R4 - Writing one to general bit 7 turns the enable pin into a dimming input.
// R5 - In dimming mode group A current flows while the pin is high and stops while it is low.
// R6 - The host writes zero to general bit 7 to give the pin its enable role back.
// R7 - Each channel brightness is a 6-bit code choosing one of 64 exponential levels.
// R8 - A fixed table maps code 0 to 0.125 percent up to code 63 at 100 percent, rising monotonically.
// R9 - A change of group A code walks through the table entries at the step rate instead of jumping.
// R10 - Step rate field 00, 01, 10, 11 gives 0.1 ms, 25 ms, 50 ms, 100 ms per step.
// R11 - Default banks are 2,1,1,1,1 with the first two in group A, and up to all six may join group A.
// R12 - Pump output below 2 V shuts pump and outputs, leaves bypass on, and soft-starts when it clears.
// R13 - Pump stays unity gain until the worst LED loses regulation, then 1.5x, back when lowest cathode is over 1.8 V.
// R14 - The step rate sits in config bits 1 and 0.
// R15 - A ramp moves exactly one step per interval toward the target and stops on reaching it.
// R16 - A new target during a ramp is pursued from the code applied at that moment.
module lbs_led_sequencer #(
   parameter integer STEP0_CYC = `LBS_STEP0_US * `LBS_CLK_MHZ,
   parameter integer STEP1_CYC = `LBS_STEP1_US * `LBS_CLK_MHZ,
   parameter integer STEP2_CYC = `LBS_STEP2_US * `LBS_CLK_MHZ,
   parameter integer STEP3_CYC = `LBS_STEP3_US * `LBS_CLK_MHZ,
   parameter integer SOFT_CYC  = `LBS_SOFT_US * `LBS_CLK_MHZ
) (
   input  wire        clock,
   input  wire        sys_rst,
   input  wire        enPin,
   input  wire        pumpLow,
   input  wire        headroomLost,
   input  wire        cathodeHigh,
   input  wire        wrStrobe,
   input  wire [2:0]  wrSel,
   input  wire [7:0]  wrData,
   input  wire [2:0]  rdSel,
   output reg  [7:0]  rdData_q,
   output reg         serialActive_q,
   output reg  [5:0]  ledOn_q,
   output reg  [35:0] ledCodes_q,
   output reg  [1:0]  fullScaleSel_q,
   output wire [16:0] levelA_q,
   output reg         rampBusy_q,
   output reg         pumpOn_q,
   output reg         bypassOn_q,
   output reg         pumpHighGain_q
);
   localparam ST_RUN   = 2'b00;
   localparam ST_FAULT = 2'b01;
   localparam ST_SOFT  = 2'b10;

   // Three-stage synchronisers for the pin and the analog comparators
   reg [2:0]  enSync_q;
   reg [2:0]  lowSync_q;
   reg [2:0]  hrSync_q;
   reg [2:0]  chSync_q;
   reg        enLevel_q;
   reg        lowLevel_q;
   reg        hrLevel_q;
   reg        chLevel_q;

   reg [7:0]  general_q;
   reg [7:0]  config_q;
   reg [5:0]  codeA_q;
   reg [5:0]  code3_q;
   reg [5:0]  code4_q;
   reg [5:0]  code5_q;
   reg [5:0]  code6_q;
   reg [5:0]  appliedA_q;
   reg [22:0] stepCnt_q;
   reg [22:0] stepLen;
   reg [1:0]  state_q;
   reg [13:0] softCnt_q;

   wire       pwmMode  = general_q[`LBS_GEN_PWM];
   wire       disabled = ~pwmMode & ~enLevel_q;
   wire       writeOk  = wrStrobe & ~disabled;
   wire [5:0] inA      = {config_q[`LBS_CFG_S6A:`LBS_CFG_S3A], 2'b11};

   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         enSync_q   <= 3'h0;
         lowSync_q  <= 3'h0;
         hrSync_q   <= 3'h0;
         chSync_q   <= 3'h0;
         enLevel_q  <= 1'b0;
         lowLevel_q <= 1'b0;
         hrLevel_q  <= 1'b0;
         chLevel_q  <= 1'b0;
      end else begin
         enSync_q  <= {enSync_q[1:0], enPin};
         lowSync_q <= {lowSync_q[1:0], pumpLow};
         hrSync_q  <= {hrSync_q[1:0], headroomLost};
         chSync_q  <= {chSync_q[1:0], cathodeHigh};
         // A level is taken only once the last two stages agree
         if (enSync_q[1] == enSync_q[2]) begin
            enLevel_q <= enSync_q[2];
         end
         if (lowSync_q[1] == lowSync_q[2]) begin
            lowLevel_q <= lowSync_q[2];
         end
         if (hrSync_q[1] == hrSync_q[2]) begin
            hrLevel_q <= hrSync_q[2];
         end
         if (chSync_q[1] == chSync_q[2]) begin
            chLevel_q <= chSync_q[2];
         end
      end
   end

   // Register file
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         general_q <= `LBS_GENERAL_RST;
         config_q  <= `LBS_CONFIG_RST;
         codeA_q   <= `LBS_CODE_RST;
         code3_q   <= `LBS_CODE_RST;
         code4_q   <= `LBS_CODE_RST;
         code5_q   <= `LBS_CODE_RST;
         code6_q   <= `LBS_CODE_RST;
      end else if (disabled) begin
         general_q <= `LBS_GENERAL_RST; // R1
         config_q  <= `LBS_CONFIG_RST; // R1
         codeA_q   <= `LBS_CODE_RST; // R1
         code3_q   <= `LBS_CODE_RST;
         code4_q   <= `LBS_CODE_RST;
         code5_q   <= `LBS_CODE_RST;
         code6_q   <= `LBS_CODE_RST;
      end else if (writeOk) begin // R3
         case (wrSel)
            `LBS_SEL_GENERAL: general_q <= wrData; // R2 R4
            `LBS_SEL_CONFIG:  config_q  <= wrData; // R11 R14
            // Top two bits of the code registers are fixed and ignore writes
            `LBS_SEL_CHA:     codeA_q   <= wrData[5:0]; // R7
            `LBS_SEL_CH3:     code3_q   <= wrData[5:0];
            `LBS_SEL_CH4:     code4_q   <= wrData[5:0];
            `LBS_SEL_CH5:     code5_q   <= wrData[5:0];
            `LBS_SEL_CH6:     code6_q   <= wrData[5:0];
            default: begin
            end
         endcase
      end
   end

   always @* begin
      case (config_q[`LBS_CFG_RS_HI:`LBS_CFG_RS_LO]) // R10 R14
         2'b00:   stepLen = STEP0_CYC[22:0];
         2'b01:   stepLen = STEP1_CYC[22:0];
         2'b10:   stepLen = STEP2_CYC[22:0];
         default: stepLen = STEP3_CYC[22:0];
      endcase
   end

   // Group A ramp; the timer restarts whenever the target is reached
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         appliedA_q <= `LBS_CODE_RST;
         stepCnt_q  <= 23'h00_0000;
         rampBusy_q <= 1'b0;
      end else if (disabled) begin
         appliedA_q <= `LBS_CODE_RST;
         stepCnt_q  <= 23'h00_0000;
         rampBusy_q <= 1'b0;
      end else if (appliedA_q == codeA_q) begin
         stepCnt_q  <= 23'h00_0000; // R15
         rampBusy_q <= 1'b0;
      end else begin
         rampBusy_q <= 1'b1; // R9
         // A shortened rate mid-step takes effect at once
         if (stepCnt_q >= stepLen - 23'h00_0001) begin
            stepCnt_q <= 23'h00_0000;
            if (codeA_q > appliedA_q) begin // R16
               appliedA_q <= appliedA_q + 6'h01; // R15
            end else begin
               appliedA_q <= appliedA_q - 6'h01; // R15
            end
         end else begin
            stepCnt_q <= stepCnt_q + 23'h00_0001; // R10
         end
      end
   end

   lbs_level_rom uLevelRom (
      .clock   (clock),
      .sys_rst (sys_rst),
      .code    (appliedA_q),
      .level_q (levelA_q)
   ); // R8

   // Pump short-circuit handling and gain choice
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_q        <= ST_RUN;
         softCnt_q      <= 14'h0000;
         pumpHighGain_q <= 1'b0;
      end else if (disabled) begin
         state_q        <= ST_RUN;
         softCnt_q      <= 14'h0000;
         pumpHighGain_q <= 1'b0;
      end else begin
         case (state_q)
            ST_RUN: begin
               if (lowLevel_q) begin
                  state_q        <= ST_FAULT; // R12
                  pumpHighGain_q <= 1'b0;
               end else if (pumpHighGain_q && chLevel_q) begin
                  pumpHighGain_q <= 1'b0; // R13
               end else if (!pumpHighGain_q && hrLevel_q) begin
                  pumpHighGain_q <= 1'b1; // R13
               end
            end
            ST_FAULT: begin
               softCnt_q <= 14'h0000;
               if (!lowLevel_q) begin
                  state_q <= ST_SOFT; // R12
               end
            end
            ST_SOFT: begin
               if (lowLevel_q) begin
                  state_q <= ST_FAULT;
               end else if (softCnt_q >= SOFT_CYC[13:0] - 14'h0001) begin
                  state_q <= ST_RUN; // R12
               end else begin
                  softCnt_q <= softCnt_q + 14'h0001;
               end
            end
            default: begin
               state_q <= ST_RUN;
            end
         endcase
      end
   end

   // Channel grouping and output gating
   reg [5:0]  onD;
   reg [35:0] codesD;
   reg [5:0]  tie4;
   reg [5:0]  tie6;
   always @* begin
      tie4 = code4_q;
      tie6 = code6_q;
      if (config_q[`LBS_CFG_T34] && !config_q[`LBS_CFG_S3A] && !config_q[`LBS_CFG_S4A]) begin
         tie4 = code3_q; // R11
      end
      if (config_q[`LBS_CFG_T56] && !config_q[`LBS_CFG_S5A] && !config_q[`LBS_CFG_S6A]) begin
         tie6 = code5_q; // R11
      end
      codesD = {tie6, code5_q, tie4, code3_q, appliedA_q, appliedA_q};
      onD    = {general_q[`LBS_GEN_EN6:`LBS_GEN_EN3], {2{general_q[`LBS_GEN_ENA]}}};
   end

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : gChan
         always @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               ledOn_q[gi]               <= 1'b0;
               ledCodes_q[gi*6 +: 6]     <= `LBS_CODE_RST;
            end else if (inA[gi]) begin
               ledCodes_q[gi*6 +: 6] <= appliedA_q; // R11
               // Dimming pin gates group A only
               ledOn_q[gi] <= ~disabled & (state_q == ST_RUN) & general_q[`LBS_GEN_ENA]
                              & (~pwmMode | enLevel_q); // R5
            end else begin
               ledCodes_q[gi*6 +: 6] <= codesD[gi*6 +: 6];
               ledOn_q[gi]           <= ~disabled & (state_q == ST_RUN) & onD[gi]; // R2 R12
            end
         end
      end
   endgenerate

   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rdData_q       <= 8'h00;
         serialActive_q <= 1'b0;
         fullScaleSel_q <= 2'b00;
         pumpOn_q       <= 1'b0;
         bypassOn_q     <= 1'b0;
      end else begin
         serialActive_q <= ~disabled; // R1 R2
         fullScaleSel_q <= general_q[`LBS_GEN_FS_HI:`LBS_GEN_FS_LO];
         pumpOn_q       <= ~disabled & (state_q == ST_RUN); // R12
         bypassOn_q     <= ~disabled & (state_q != ST_RUN); // R12
         if (disabled) begin
            rdData_q <= 8'h00;
         end else begin
            case (rdSel) // R3
               `LBS_SEL_GENERAL: rdData_q <= general_q;
               `LBS_SEL_CONFIG:  rdData_q <= config_q;
               `LBS_SEL_CHA:     rdData_q <= {`LBS_RSVD_BITS, codeA_q};
               `LBS_SEL_CH3:     rdData_q <= {`LBS_RSVD_BITS, code3_q};
               `LBS_SEL_CH4:     rdData_q <= {`LBS_RSVD_BITS, code4_q};
               `LBS_SEL_CH5:     rdData_q <= {`LBS_RSVD_BITS, code5_q};
               `LBS_SEL_CH6:     rdData_q <= {`LBS_RSVD_BITS, code6_q};
               default:          rdData_q <= 8'h00;
            endcase
         end
      end
   end
endmodule // lbs_led_sequencer

//--- verif/lbs_seq_properties.sv
`timescale 1ns/1ps
module lbs_seq_properties (
   input wire        clock,
   input wire        sys_rst,
   input wire [7:0]  rdData_q,
   input wire        serialActive_q,
   input wire [5:0]  ledOn_q,
   input wire [35:0] ledCodes_q,
   input wire [16:0] levelA_q,
   input wire        pumpOn_q,
   input wire        bypassOn_q,
   input wire        pumpHighGain_q
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   wire [5:0] codeA = ledCodes_q[5:0];

   property p_quietWhenOff;
      !serialActive_q ##1 !serialActive_q |-> rdData_q == 8'h00;
   endproperty
   a_quietWhenOff: assert property (p_quietWhenOff) else $error("read data not zero while disabled");
   // Three cycles of margin: codes lag the applied code by one register
   property p_defaultsWhenOff;
      !serialActive_q [*3] |-> ledOn_q == 6'h00 && ledCodes_q == {6{6'h3F}};
   endproperty
   a_defaultsWhenOff: assert property (p_defaultsWhenOff) else $error("outputs not at default while disabled");
   property p_singleStep;
      serialActive_q && $past(serialActive_q) && codeA != $past(codeA)
         |-> (codeA - $past(codeA) == 6'h01) || ($past(codeA) - codeA == 6'h01);
   endproperty
   a_singleStep: assert property (p_singleStep) else $error("group code moved by more than one step");
   property p_stepSpacing;
      serialActive_q && $past(serialActive_q) && $changed(codeA) |=> ($stable(codeA) || !serialActive_q) [*7];
   endproperty
   a_stepSpacing: assert property (p_stepSpacing) else $error("group code stepped too soon");
   property p_faultDark;
      bypassOn_q [*2] |-> ledOn_q == 6'h00 && !pumpHighGain_q;
   endproperty
   a_faultDark: assert property (p_faultDark) else $error("outputs lit during fault");
   property p_bypassAlone;
      bypassOn_q |-> !pumpOn_q;
   endproperty
   a_bypassAlone: assert property (p_bypassAlone) else $error("pump running with bypass");
   property p_gainWithPump;
      pumpHighGain_q |-> pumpOn_q;
   endproperty
   a_gainWithPump: assert property (p_gainWithPump) else $error("high gain without pump");
   property p_levelEnds;
      (codeA == 6'h00 |-> levelA_q == 17'h0_007D) and (codeA == 6'h3F |-> levelA_q == 17'h1_86A0);
   endproperty
   a_levelEnds: assert property (p_levelEnds) else $error("level table end value wrong");
   property p_pairA;
      ledOn_q[0] == ledOn_q[1] && ledCodes_q[11:6] == codeA;
   endproperty
   a_pairA: assert property (p_pairA) else $error("primary pair differs");

   c_step: cover property (serialActive_q && $changed(codeA));
   c_fault: cover property ($rose(bypassOn_q));
   c_dim: cover property (serialActive_q && $fell(ledOn_q[0]));
   c_gain: cover property ($rose(pumpHighGain_q));
endmodule // lbs_seq_properties

bind lbs_led_sequencer lbs_seq_properties lbs_seq_properties_inst (.clock(clock), .sys_rst(sys_rst),
   .rdData_q(rdData_q), .serialActive_q(serialActive_q), .ledOn_q(ledOn_q), .ledCodes_q(ledCodes_q),
   .levelA_q(levelA_q), .pumpOn_q(pumpOn_q), .bypassOn_q(bypassOn_q), .pumpHighGain_q(pumpHighGain_q));

//--- verif/lbs_host_model.sv
`timescale 1ns/1ps
module lbs_host_model (
   input  wire  pwmRun,
   input  wire  enLevel,
   output logic enPin
);
   initial enPin = 1'b0;
   // Square wave of 160 ns period while dimming, otherwise a plain enable level
   always begin
      #80;
      enPin = pwmRun ? ~enPin : enLevel;
   end
endmodule // lbs_host_model

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic        clock;
   logic        sys_rst;
   logic        pwmRun;
   logic        enLevel;
   wire         enPin;
   logic        pumpLow;
   logic        headroomLost;
   logic        cathodeHigh;
   logic        wrStrobe;
   logic [2:0]  wrSel;
   logic [7:0]  wrData;
   logic [2:0]  rdSel;
   wire  [7:0]  rdData_q;
   wire         serialActive_q;
   wire  [5:0]  ledOn_q;
   wire  [35:0] ledCodes_q;
   wire  [1:0]  fullScaleSel_q;
   wire  [16:0] levelA_q;
   wire         rampBusy_q;
   wire         pumpOn_q;
   wire         bypassOn_q;
   wire         pumpHighGain_q;
   int          fails;
   int          checks_done;
   int          n;
   int          hi;
   int          lo;

   lbs_led_sequencer #(.STEP0_CYC(8), .STEP1_CYC(16), .STEP2_CYC(24), .STEP3_CYC(32), .SOFT_CYC(10))
      lbs_led_sequencer_inst (.clock(clock), .sys_rst(sys_rst), .enPin(enPin), .pumpLow(pumpLow),
      .headroomLost(headroomLost), .cathodeHigh(cathodeHigh), .wrStrobe(wrStrobe), .wrSel(wrSel),
      .wrData(wrData), .rdSel(rdSel), .rdData_q(rdData_q), .serialActive_q(serialActive_q),
      .ledOn_q(ledOn_q), .ledCodes_q(ledCodes_q), .fullScaleSel_q(fullScaleSel_q), .levelA_q(levelA_q),
      .rampBusy_q(rampBusy_q), .pumpOn_q(pumpOn_q), .bypassOn_q(bypassOn_q), .pumpHighGain_q(pumpHighGain_q));
   lbs_host_model lbs_host_model_inst (.pwmRun(pwmRun), .enLevel(enLevel), .enPin(enPin));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge clock);
   endtask

   task automatic wr(input logic [2:0] sel, input logic [7:0] d);
      @(negedge clock);
      wrSel = sel;
      wrData = d;
      wrStrobe = 1'b1;
      @(negedge clock);
      wrStrobe = 1'b0;
   endtask

   task automatic rd(input logic [2:0] sel, input logic [7:0] exp);
      @(negedge clock);
      rdSel = sel;
      cyc(2);
      chk(rdData_q, exp);
   endtask

   // Cycles from the write until the ramp settles; busy rises two edges late
   task automatic ramp(input logic [5:0] target, output int cnt);
      wr(3'h2, {2'b00, target});
      cnt = 1;
      while (cnt < 3 || (rampBusy_q !== 1'b0 && cnt < 2000)) begin
         cyc(1);
         cnt++;
      end
      cyc(3);
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      cyc(30000);
      fails++;
      conclude();
   end

   initial begin
      sys_rst = 1'b1;
      pwmRun = 1'b0;
      enLevel = 1'b0;
      pumpLow = 1'b0;
      headroomLost = 1'b0;
      cathodeHigh = 1'b0;
      wrStrobe = 1'b0;
      wrSel = 3'h0;
      wrData = 8'h00;
      rdSel = 3'h0;
      fails = 0;
      checks_done = 0;
      cyc(12);
      sys_rst = 1'b0;
      cyc(8);
      wr(3'h0, 8'h1F);
      chk(serialActive_q, 1'b0);
      rd(3'h0, 8'h00);
      enLevel = 1'b1;
      cyc(12);
      chk({serialActive_q, ledOn_q}, {1'b1, 6'h00});
      for (int s = 0; s < 8; s++)
         rd(s[2:0], (s >= 2 && s <= 6) ? 8'hFF : 8'h00);
      wr(3'h0, 8'h61);
      cyc(2);
      chk({fullScaleSel_q, ledOn_q}, {2'h3, 6'h03});
      wr(3'h0, 8'h1F);
      cyc(2);
      chk(ledOn_q, 6'h3F);
      rd(3'h0, 8'h1F);
      wr(3'h3, 8'h15);
      rd(3'h3, 8'hD5);
      chk(ledCodes_q[17:12], 6'h15);
      for (int r = 0; r < 4; r++) begin
         wr(3'h1, r[7:0]);
         rd(3'h1, r[7:0]);
         ramp(6'h3D - 6'(2 * r), n);
         chk(n >= 16 * (r + 1) && n <= 16 * (r + 1) + 6, 1'b1);
      end
      chk({ledCodes_q[5:0], levelA_q}, {6'h37, 17'h0_D178});
      wr(3'h1, 8'h00);
      wr(3'h2, 8'h00);
      cyc(100);
      chk(rampBusy_q, 1'b1);
      ramp(6'h05, n);
      chk({ledCodes_q[5:0], levelA_q}, {6'h05, 17'h0_01B6});
      ramp(6'h00, n);
      chk(levelA_q, 17'h0_007D);
      chk(n >= 40 && n <= 46, 1'b1);
      wr(3'h1, 8'h04);
      cyc(4);
      chk(ledCodes_q[17:12], 6'h00);
      wr(3'h1, 8'h40);
      cyc(4);
      chk({ledCodes_q[23:18], ledCodes_q[17:12]}, {6'h15, 6'h15});
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h83);
      pwmRun = 1'b1;
      hi = 0;
      lo = 0;
      repeat (64) begin
         cyc(1);
         hi += (ledOn_q[0] === 1'b1);
         lo += (ledOn_q[0] === 1'b0);
         chk(ledOn_q[2], 1'b1);
      end
      chk(hi > 8 && lo > 8 && serialActive_q === 1'b1, 1'b1);
      pwmRun = 1'b0;
      cyc(8);
      wr(3'h0, 8'h03);
      rd(3'h0, 8'h03);
      enLevel = 1'b0;
      cyc(12);
      chk(serialActive_q, 1'b0);
      enLevel = 1'b1;
      cyc(12);
      rd(3'h0, 8'h00);
      wr(3'h0, 8'h1F);
      cyc(20);
      chk(pumpOn_q, 1'b1);
      pumpLow = 1'b1;
      cyc(8);
      chk({pumpOn_q, bypassOn_q, ledOn_q}, {1'b0, 1'b1, 6'h00});
      pumpLow = 1'b0;
      n = 0;
      while (pumpOn_q !== 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
      chk(n >= 10 && n <= 18, 1'b1);
      cyc(2);
      chk(ledOn_q, 6'h3F);
      headroomLost = 1'b1;
      cyc(8);
      chk(pumpHighGain_q, 1'b1);
      headroomLost = 1'b0;
      cathodeHigh = 1'b1;
      cyc(8);
      chk(pumpHighGain_q, 1'b0);
      cathodeHigh = 1'b0;
      conclude();
   end
endmodule // testbench
